/* File: inc/fan_alert_pkg.sv */
package fan_alert_pkg;

    // Register byte addresses
    localparam logic [7:0] MASK1_ADDR = 8'h74;
    localparam logic [7:0] MASK2_ADDR = 8'h75;
    localparam logic [7:0] VLOW_ADDR  = 8'h76;
    localparam logic [7:0] TLOW_ADDR  = 8'h77;
    localparam logic [7:0] CFG3_ADDR  = 8'h78;

    // Reset values
    localparam logic [7:0] MASK1_RST = 8'h00;
    localparam logic [7:0] MASK2_RST = 8'h00;
    localparam logic [7:0] CFG3_RST  = 8'h00;

    // Writable bits; others read zero
    localparam logic [7:0] MASK1_WR = 8'hF6;
    localparam logic [7:0] MASK2_WR = 8'hFC;

    // Measurement mask bits that gate alerts
    localparam logic [7:0] MASK1_CHAN = 8'h76;
    // Secondary status bits that can alert
    localparam logic [7:0] STAT2_USED = 8'hFE;

    // Field positions
    localparam int SUPPRESS_SEC_BIT = 7;
    localparam int FAN4_TIMER_BIT   = 5;
    localparam int ALERT_EN_BIT     = 0;
    localparam int THERMAL_ALARM_PIN_EN_BIT     = 1;
    localparam int BOOST_BIT        = 2;
    localparam int FAST_BIT         = 3;
    localparam int DC_LSB           = 4;

    // Pin-function code that puts the thermal alarm on the pin
    localparam logic [1:0] THERMAL_ALARM_PIN_FUNC_SEL = 2'h1;
    // Direction field code that makes the thermal pin an input
    localparam logic [2:0] THERMAL_ALARM_PIN_DIR_IN   = 3'h0;

    // Timing
    localparam longint CLK_KHZ  = 50000;
    localparam longint TICK_US  = 22760;
    localparam longint SLOW_MS  = 1000;
    localparam longint FAST_MS  = 250;
    localparam longint TICK_CYC = TICK_US * CLK_KHZ / 1000;
    localparam longint SLOW_CYC = SLOW_MS * CLK_KHZ;
    localparam longint FAST_CYC = FAST_MS * CLK_KHZ;

    // Readings held for low-bit registers
    localparam int NUM_READ = 5;
    localparam int NUM_VOLT = 2;

endpackage : fan_alert_pkg

/* File: design/alert_mask_and_fan_config_regs.sv */
module alert_mask_and_fan_config_regs #(
    parameter longint TICK_CYCLES = fan_alert_pkg::TICK_CYC,
    parameter longint SLOW_CYCLES = fan_alert_pkg::SLOW_CYC,
    parameter longint FAST_CYCLES = fan_alert_pkg::FAST_CYC
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Status from the status registers
    input  wire logic [7:0]  status1,
    input  wire logic [7:0]  status2,
    input  wire logic        timer_flag_clear,
    output logic             timer_flag,
    // Settings held in other registers
    input  wire logic        lock_bit,
    input  wire logic [1:0]  shared_pin_function_select,
    input  wire logic [2:0]  thermal_alarm_pin_dir_sel,
    input  wire logic [7:0]  thermal_alarm_pin_limit,
    // Live 10-bit readings: core, main, remote1, local, remote2
    input  wire logic [49:0] reading_live,
    input  wire logic [4:0]  high_byte_read,
    output logic      [39:0] reading_high,
    // Thermal alarm pin, active low
    input  wire logic        thermal_alarm_pin_in,
    input  wire logic        overtemp_trip,
    output logic             thermal_alarm_pin_out,
    output logic             thermal_alarm_pin_oe,
    output logic      [7:0]  thermal_alarm_pin_time,
    // Shared PWM2 / alert pin
    input  wire logic        pwm2_drive,
    output logic             pwm2_pin_out,
    output logic             alert_n,
    // Fan control outputs
    output logic             fans_full_speed,
    output logic             tach_measure_strobe,
    output logic      [3:0]  continuous_tach,
    output logic      [3:0]  stretch_disable
);

    ////////////////////////////////////////////////////////////////
    // Registers and decode

    logic [7:0]  mask1_q;      // Measurement alert masks
    logic [7:0]  mask2_q;      // Fault alert masks
    logic [7:0]  cfg3_q;       // Pin and tach config
    logic [9:0]  snap_q [5];   // Held readings
    logic [4:0]  pend_q;       // Highs still to be read
    logic [7:0]  vlow;         // Voltage low-bit view
    logic [7:0]  tlow;         // Temperature low-bit view
    logic        frz_v;        // Voltage group frozen
    logic        frz_t;        // Temperature group frozen
    logic        rd_v;         // Voltage low-bit read
    logic        rd_t;         // Temperature low-bit read

    assign rd_v = reg_rd && (reg_addr == fan_alert_pkg::VLOW_ADDR);
    assign rd_t = reg_rd && (reg_addr == fan_alert_pkg::TLOW_ADDR);

    // Mask registers
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            mask1_q <= fan_alert_pkg::MASK1_RST;
            mask2_q <= fan_alert_pkg::MASK2_RST;
        end
        else if (reg_wr && reg_addr == fan_alert_pkg::MASK1_ADDR)
        begin
            mask1_q <= reg_wdata & fan_alert_pkg::MASK1_WR;
        end
        else if (reg_wr && reg_addr == fan_alert_pkg::MASK2_ADDR)
        begin
            // Overtemp mask bit stays read-only
            mask2_q <= reg_wdata & fan_alert_pkg::MASK2_WR;
        end
    end

    // Config three
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            cfg3_q <= fan_alert_pkg::CFG3_RST;
        end
        else if (reg_wr && reg_addr == fan_alert_pkg::CFG3_ADDR && !lock_bit)
        begin
            cfg3_q <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Coherent readings

    assign frz_v = |pend_q[fan_alert_pkg::NUM_VOLT-1:0];
    assign frz_t = |pend_q[fan_alert_pkg::NUM_READ-1:fan_alert_pkg::NUM_VOLT];

    genvar gi;
    generate
        for (gi = 0; gi < fan_alert_pkg::NUM_READ; gi++)
        begin : g_read
            localparam bit IS_V = (gi < fan_alert_pkg::NUM_VOLT);
            logic grp_rd;      // Low-bit read of this group
            logic grp_frz;     // This group frozen
            assign grp_rd  = IS_V ? rd_v : rd_t;
            assign grp_frz = IS_V ? frz_v : frz_t;

            always_ff @(posedge ref_clk)
            begin
                if (sys_rst)
                begin
                    snap_q[gi] <= 10'h000;
                end
                else if (!grp_frz && !grp_rd)
                begin
                    snap_q[gi] <= reading_live[gi*10 +: 10];
                end
            end

            always_ff @(posedge ref_clk)
            begin
                if (sys_rst)
                begin
                    pend_q[gi] <= 1'b0;
                end
                else if (grp_rd)
                begin
                    pend_q[gi] <= 1'b1;
                end
                else if (high_byte_read[gi])
                begin
                    pend_q[gi] <= 1'b0;
                end
            end

            // High bytes taken from the same snapshot
            always_ff @(posedge ref_clk)
            begin
                if (sys_rst)
                begin
                    reading_high[gi*8 +: 8] <= 8'h00;
                end
                else
                begin
                    reading_high[gi*8 +: 8] <= snap_q[gi][9:2];
                end
            end
        end
    endgenerate

    assign vlow = {2'h0, snap_q[1][1:0], snap_q[0][1:0], 2'h0};
    assign tlow = {snap_q[4][1:0], snap_q[3][1:0], snap_q[2][1:0], 2'h0};

    // Read data, one cycle after the strobe
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd)
        begin
            if (reg_addr == fan_alert_pkg::MASK1_ADDR)
            begin
                reg_rdata <= mask1_q;
            end
            else if (reg_addr == fan_alert_pkg::MASK2_ADDR)
            begin
                reg_rdata <= mask2_q;
            end
            else if (reg_addr == fan_alert_pkg::VLOW_ADDR)
            begin
                reg_rdata <= vlow;
            end
            else if (reg_addr == fan_alert_pkg::TLOW_ADDR)
            begin
                reg_rdata <= tlow;
            end
            else if (reg_addr == fan_alert_pkg::CFG3_ADDR)
            begin
                reg_rdata <= cfg3_q;
            end
            else
            begin
                // Unmapped reads zero
                reg_rdata <= 8'h00;
            end
        end
        else
        begin
            reg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Thermal alarm pin

    logic [2:0] th_sync_q;     // Pin synchroniser
    logic       th_lvl_q;      // Filtered pin level
    logic       th_func;       // Thermal function active
    logic       th_is_in;      // Pin used as input
    logic       th_asserted;   // Input asserted

    assign th_func = cfg3_q[fan_alert_pkg::THERMAL_ALARM_PIN_EN_BIT]
                  && shared_pin_function_select == fan_alert_pkg::THERMAL_ALARM_PIN_FUNC_SEL;
    assign th_is_in    = th_func && thermal_alarm_pin_dir_sel == fan_alert_pkg::THERMAL_ALARM_PIN_DIR_IN;
    assign th_asserted = th_is_in && !th_lvl_q;

    // Three-stage sampling of the pin
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            th_sync_q <= 3'h7;
            th_lvl_q  <= 1'b1;
        end
        else
        begin
            th_sync_q <= {th_sync_q[1:0], thermal_alarm_pin_in};
            if (th_sync_q[1] == th_sync_q[2])
            begin
                th_lvl_q <= th_sync_q[2];
            end
        end
    end

    // Drive low on overtemp when an output
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            thermal_alarm_pin_out <= 1'b1;
            thermal_alarm_pin_oe  <= 1'b0;
        end
        else
        begin
            thermal_alarm_pin_out <= 1'b0;
            thermal_alarm_pin_oe  <= th_func && !th_is_in && overtemp_trip;
        end
    end

    // boost runs fans at full duty while the thermal input is asserted
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            fans_full_speed <= 1'b0;
        end
        else
        begin
            fans_full_speed <= th_asserted && cfg3_q[fan_alert_pkg::BOOST_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////
    // Assertion timer

    logic [31:0] tick_cnt_q;   // Resolution prescaler
    logic        over_q;       // Limit already passed
    logic        over_now;     // Limit reached

    assign over_now = th_asserted && (thermal_alarm_pin_time >= thermal_alarm_pin_limit);

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || !th_asserted)
        begin
            tick_cnt_q <= 32'h0;
            thermal_alarm_pin_time <= 8'h00;
        end
        else if (tick_cnt_q == 32'(TICK_CYCLES - 1))
        begin
            tick_cnt_q <= 32'h0;
            if (thermal_alarm_pin_time != 8'hFF)
            begin
                thermal_alarm_pin_time <= thermal_alarm_pin_time + 8'h01;
            end
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
        end
    end

    // sticky timer event, set beats clear
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            over_q     <= 1'b0;
            timer_flag <= 1'b0;
        end
        else
        begin
            over_q <= over_now;
            if (over_now && !over_q)
            begin
                timer_flag <= 1'b1;
            end
            else if (timer_flag_clear)
            begin
                timer_flag <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Alert

    logic [7:0] st2;           // Secondary status seen
    logic       hit1;          // Unmasked measurement alert
    logic       hit2;          // Secondary alert

    // bit 5 is fan 4 or timer event
    assign st2 = th_func ? {status2[7:6], timer_flag, status2[4:0]} : status2;
    assign hit1 = |(status1 & ~mask1_q & fan_alert_pkg::MASK1_CHAN);
    assign hit2 = |(st2 & fan_alert_pkg::STAT2_USED
                  & (~mask2_q | {8{~mask1_q[fan_alert_pkg::SUPPRESS_SEC_BIT]}}));

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            alert_n <= 1'b1;
        end
        else
        begin
            alert_n <= !(hit1 || hit2);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            pwm2_pin_out <= 1'b0;
        end
        else if (cfg3_q[fan_alert_pkg::ALERT_EN_BIT])
        begin
            pwm2_pin_out <= !(hit1 || hit2);
        end
        else
        begin
            pwm2_pin_out <= pwm2_drive;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Tachometer timing

    logic [31:0] rate_cnt_q;   // Measurement interval count
    logic [31:0] rate_end;     // Interval length

    assign rate_end = cfg3_q[fan_alert_pkg::FAST_BIT] ? 32'(FAST_CYCLES - 1)
                                                      : 32'(SLOW_CYCLES - 1);

    // Measurement strobe
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            rate_cnt_q          <= 32'h0;
            tach_measure_strobe <= 1'b0;
        end
        else if (rate_cnt_q >= rate_end)
        begin
            rate_cnt_q          <= 32'h0;
            tach_measure_strobe <= 1'b1;
        end
        else
        begin
            rate_cnt_q          <= rate_cnt_q + 32'h1;
            tach_measure_strobe <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            continuous_tach <= 4'h0;
            stretch_disable <= 4'h0;
        end
        else
        begin
            continuous_tach <= cfg3_q[fan_alert_pkg::DC_LSB +: 4];
            stretch_disable <= cfg3_q[fan_alert_pkg::DC_LSB +: 4];
        end
    end

endmodule : alert_mask_and_fan_config_regs

/* File: tb/fan_cfg_assertions.sv */
module fan_cfg_checker (
    // Clock, reset and register port
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    // Status and settings
    input wire logic [7:0]  status1,
    input wire logic [7:0]  status2,
    input wire logic        timer_flag,
    input wire logic        lock_bit,
    input wire logic [2:0]  thermal_alarm_pin_dir_sel,
    input wire logic [4:0]  high_byte_read,
    input wire logic [39:0] reading_high,
    // Pins and fan outputs
    input wire logic        thermal_alarm_pin_in,
    input wire logic        thermal_alarm_pin_oe,
    input wire logic [7:0]  thermal_alarm_pin_time,
    input wire logic        alert_n,
    input wire logic        fans_full_speed,
    input wire logic        tach_measure_strobe,
    input wire logic [3:0]  continuous_tach,
    input wire logic [3:0]  stretch_disable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    // Read of each low-bit register
    sequence vlow_read;
        reg_rd && reg_addr == fan_alert_pkg::VLOW_ADDR;
    endsequence
    sequence tlow_read;
        reg_rd && reg_addr == fan_alert_pkg::TLOW_ADDR;
    endsequence
    // Core high byte left unread for three cycles
    sequence core_unread;
        !high_byte_read[0] [*3];
    endsequence

    a_freeze_core_hold: assert property (vlow_read ##1 core_unread |-> $stable(reading_high[7:0]))
        else $error("core high byte moved while frozen");
    a_vlow_spare_bits: assert property (vlow_read |=> reg_rdata[7:6] == 2'h0 && reg_rdata[1:0] == 2'h0)
        else $error("voltage low-bit spare field not zero");
    a_tlow_spare_bits: assert property (tlow_read |=> reg_rdata[1:0] == 2'h0)
        else $error("temperature low-bit spare field not zero");
    a_dc_pair_match: assert property (continuous_tach == stretch_disable)
        else $error("continuous tach and stretch disable differ");
    a_lock_keeps_cfg: assert property (lock_bit [*4] |-> $stable(continuous_tach))
        else $error("config changed while locked");
    a_quiet_alert_off: assert property (status1 == 8'h00 && status2 == 8'h00 && !timer_flag |=> alert_n)
        else $error("alert with no status set");
    a_input_no_drive: assert property (thermal_alarm_pin_dir_sel == 3'h0 [*2] |-> !thermal_alarm_pin_oe)
        else $error("thermal pin driven while an input");
    a_boost_idle_pin: assert property (thermal_alarm_pin_in [*8] |-> !fans_full_speed)
        else $error("full speed without thermal assertion");
    a_timer_idle_zero: assert property (thermal_alarm_pin_in [*6] |-> thermal_alarm_pin_time == 8'h00)
        else $error("assertion time not zero while idle");
    a_tach_one_pulse: assert property ($rose(tach_measure_strobe) |=> !tach_measure_strobe [*3])
        else $error("tach strobe longer than one cycle");
endmodule : fan_cfg_checker

bind alert_mask_and_fan_config_regs fan_cfg_checker i_fan_cfg_checker (.ref_clk, .sys_rst, .reg_addr, .reg_rd,
    .reg_rdata, .status1, .status2, .timer_flag, .lock_bit, .thermal_alarm_pin_dir_sel, .high_byte_read, .reading_high,
    .thermal_alarm_pin_in, .thermal_alarm_pin_oe, .thermal_alarm_pin_time, .alert_n, .fans_full_speed, .tach_measure_strobe,
    .continuous_tach, .stretch_disable);

/* File: tb/alert_mask_and_fan_config_regs_test.sv */
module alert_mask_and_fan_config_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    // Shortened counts
    localparam int TCK = 8;
    localparam int SLW = 40;
    localparam int FST = 10;
    // Design inputs
    logic        ref_clk, sys_rst, reg_wr, reg_rd, timer_flag_clear, lock_bit;
    logic [7:0]  reg_addr, reg_wdata, status1, status2, thermal_alarm_pin_limit;
    logic [1:0]  shared_pin_function_select;
    logic [2:0]  thermal_alarm_pin_dir_sel;
    logic [49:0] reading_live, snap;
    logic [4:0]  high_byte_read;
    logic        thermal_alarm_pin_in, overtemp_trip, pwm2_drive;
    // Design outputs
    logic [7:0]  reg_rdata, thermal_alarm_pin_time;
    logic [39:0] reading_high;
    logic        timer_flag, thermal_alarm_pin_out, thermal_alarm_pin_oe, pwm2_pin_out, alert_n;
    logic        fans_full_speed, tach_measure_strobe;
    logic [3:0]  continuous_tach, stretch_disable;
    // Model registers, counters, random source
    logic [7:0]  m1, m2, c3, w;
    int          err_total, cmp_count, n;
    logic [31:0] lfsr = 32'hFB6F45D4;

    alert_mask_and_fan_config_regs #(.TICK_CYCLES(TCK), .SLOW_CYCLES(SLW), .FAST_CYCLES(FST))
        i_alert_mask_and_fan_config_regs (.ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .status1, .status2, .timer_flag_clear, .timer_flag, .lock_bit, .shared_pin_function_select,
        .thermal_alarm_pin_dir_sel, .thermal_alarm_pin_limit, .reading_live, .high_byte_read, .reading_high, .thermal_alarm_pin_in,
        .overtemp_trip, .thermal_alarm_pin_out, .thermal_alarm_pin_oe, .thermal_alarm_pin_time, .pwm2_drive, .pwm2_pin_out,
        .alert_n, .fans_full_speed, .tach_measure_strobe, .continuous_tach, .stretch_disable);

    ////////////////////////////////////////////////////////////////////////////
    // Clock
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Next random word
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd

    // Expected high bytes of five readings
    function automatic logic [39:0] hi(input logic [49:0] v);
        for (int k = 0; k < 5; k++)
            hi[k*8 +: 8] = v[k*10+2 +: 8];
    endfunction : hi

    // Expected alert level from model masks
    function automatic logic exp_alert_n();
        logic sec;
        sec = |(status2 & fan_alert_pkg::STAT2_USED & (~m2 | {8{~m1[7]}}));
        return !(|(status1 & fan_alert_pkg::MASK1_CHAN & ~m1) || sec);
    endfunction : exp_alert_n

    ////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    // One-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // One-cycle read, data checked in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        chk("reg_rdata", e, reg_rdata);
    endtask : rd

    // Bounded wait for a flag
    task automatic wait_hi(ref logic s, output int c);
        c = 0;
        do
        begin
            @(posedge ref_clk);
            #1;
            c++;
        end
        while (s !== 1'b1 && c < 500);
    endtask : wait_hi

    // Reset for five cycles, model back to defaults
    task automatic do_reset();
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        m1 = 8'h00;
        m2 = 8'h00;
        c3 = 8'h00;
    endtask : do_reset

    // Counts and verdict
    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        final_report();
    end

    // Main sequence
    initial
    begin
        {sys_rst, reg_wr, reg_rd, timer_flag_clear, lock_bit, overtemp_trip, pwm2_drive} = '0;
        {reg_addr, reg_wdata, status1, status2, thermal_alarm_pin_limit, shared_pin_function_select, thermal_alarm_pin_dir_sel} = '0;
        {reading_live, high_byte_read} = '0;
        thermal_alarm_pin_in = 1'b1;
        // Reset from time zero, so no edge sees unreset state
        sys_rst = 1'b1;
        do_reset();
        rd(fan_alert_pkg::MASK1_ADDR, 8'h00);
        rd(fan_alert_pkg::MASK2_ADDR, 8'h00);
        wr(8'h7F, 8'hFF);
        rd(8'h7F, 8'h00);
        // Random masks and status, alert on the shared pin
        wr(fan_alert_pkg::CFG3_ADDR, 8'h01);
        for (int i = 0; i < 32; i++)
        begin
            m1 = 8'(rnd());
            m2 = 8'(rnd());
            wr(fan_alert_pkg::MASK1_ADDR, m1);
            wr(fan_alert_pkg::MASK2_ADDR, m2);
            m1 &= fan_alert_pkg::MASK1_WR;
            m2 &= fan_alert_pkg::MASK2_WR;
            rd(fan_alert_pkg::MASK1_ADDR, m1);
            rd(fan_alert_pkg::MASK2_ADDR, m2);
            status1 <= 8'(rnd() & rnd());
            status2 <= 8'(rnd() & rnd());
            repeat (2) @(posedge ref_clk);
            #1;
            chk("alert_n", exp_alert_n(), alert_n);
            chk("pwm2_pin_out", exp_alert_n(), pwm2_pin_out);
        end
        // Config writes with and without lock
        for (int i = 0; i < 8; i++)
        begin
            w = 8'(rnd());
            @(posedge ref_clk);
            lock_bit <= i[2];
            wr(fan_alert_pkg::CFG3_ADDR, w);
            c3 = lock_bit ? c3 : w;
            rd(fan_alert_pkg::CFG3_ADDR, c3);
            chk("continuous_tach", c3[7:4], continuous_tach);
            chk("stretch_disable", c3[7:4], stretch_disable);
        end
        lock_bit <= 1'b0;
        status1 <= 8'h00;
        status2 <= 8'h00;
        pwm2_drive <= 1'b1;
        wr(fan_alert_pkg::CFG3_ADDR, 8'h00);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("pwm2_pin_out", 1'b1, pwm2_pin_out);
        // Low bits, group freeze and partial release
        reading_live <= 50'({rnd(), rnd()});
        repeat (2) @(posedge ref_clk);
        snap = reading_live;
        rd(fan_alert_pkg::VLOW_ADDR, {2'h0, snap[11:10], snap[1:0], 2'h0});
        rd(fan_alert_pkg::TLOW_ADDR, {snap[41:40], snap[31:30], snap[21:20], 2'h0});
        // Read only the core high byte after the low-bit read; the voltage group stays frozen
        @(posedge ref_clk);
        reading_live <= ~snap;
        high_byte_read <= 5'h01;
        @(posedge ref_clk);
        high_byte_read <= 5'h00;
        repeat (3) @(posedge ref_clk);
        #1;
        chk("reading_high frozen", hi(snap), reading_high);
        high_byte_read <= 5'h1E;
        @(posedge ref_clk);
        high_byte_read <= 5'h00;
        repeat (4) @(posedge ref_clk);
        #1;
        chk("reading_high live", hi(~snap), reading_high);
        // Tach rate, slow then fast
        for (int f = 0; f < 2; f++)
        begin
            wr(fan_alert_pkg::CFG3_ADDR, {4'h0, f[0], 3'h0});
            wait_hi(tach_measure_strobe, n);
            wait_hi(tach_measure_strobe, n);
            chk("tach_gap", f ? FST : SLW, n);
        end
        // Thermal input with boost and timer, masked and unmasked
        m1 = 8'h80;
        m2 = 8'h00;
        wr(fan_alert_pkg::MASK1_ADDR, m1);
        wr(fan_alert_pkg::MASK2_ADDR, m2);
        thermal_alarm_pin_limit <= 8'h02;
        shared_pin_function_select <= 2'h1;
        wr(fan_alert_pkg::CFG3_ADDR, 8'h06);
        thermal_alarm_pin_in <= 1'b0;
        wait_hi(timer_flag, n);
        chk("timer_flag", 1'b1, timer_flag);
        chk("thermal_alarm_pin_time", 8'h02, thermal_alarm_pin_time);
        chk("fans_full_speed", 1'b1, fans_full_speed);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("alert_n timer", 1'b0, alert_n);
        wr(fan_alert_pkg::MASK2_ADDR, 8'h20);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("alert_n masked", 1'b1, alert_n);
        thermal_alarm_pin_in <= 1'b1;
        timer_flag_clear <= 1'b1;
        @(posedge ref_clk);
        timer_flag_clear <= 1'b0;
        repeat (8) @(posedge ref_clk);
        #1;
        chk("timer_flag", 1'b0, timer_flag);
        chk("fans_full_speed", 1'b0, fans_full_speed);
        chk("thermal_alarm_pin_time", 8'h00, thermal_alarm_pin_time);
        // Pin as output driven low by overtemperature
        thermal_alarm_pin_dir_sel <= 3'h1;
        overtemp_trip <= 1'b1;
        repeat (8) @(posedge ref_clk);
        #1;
        chk("thermal_alarm_pin_oe", 1'b1, thermal_alarm_pin_oe);
        chk("thermal_alarm_pin_out", 1'b0, thermal_alarm_pin_out);
        // Other pin function selected: thermal function off, pin released
        shared_pin_function_select <= 2'h2;
        repeat (2) @(posedge ref_clk);
        #1;
        chk("thermal_alarm_pin_oe off", 1'b0, thermal_alarm_pin_oe);
        // Second reset in mid-run
        do_reset();
        rd(fan_alert_pkg::CFG3_ADDR, 8'h00);
        final_report();
    end
endmodule : alert_mask_and_fan_config_regs_test
